//--- shared/iap_map.vh
// constants for the in-application flash command sequencer
`ifndef IAP_MAP_VH
`define IAP_MAP_VH
// ==================================================
// flash_config_reg fields
`define IAP_CFG_ENABLE_BIT 6
`define IAP_CFG_BANK_HI 1
`define IAP_CFG_BANK_LO 0
// ==================================================
// flash_command_reg fields and operation codes
`define IAP_CMD_IRQ_BIT 7
`define IAP_OP_CHIP_ERASE 7'h01
`define IAP_OP_BLOCK_ERASE 7'h0D
`define IAP_OP_SECTOR_ERASE 7'h0B
`define IAP_OP_BYTE_PROG 7'h0E
`define IAP_OP_BYTE_VERIFY 7'h0C
`define IAP_OP_PROG_SB1 7'h0F
`define IAP_OP_PROG_SB2 7'h03
`define IAP_OP_PROG_SB3 7'h05
`define IAP_OP_PROG_SC 7'h09
`define IAP_OP_CLK_DOUBLE 7'h08
`define IAP_OP_READ_IDENTIFICATION 7'h0C
// ==================================================
// internal operation codes
`define IAP_K_NONE 4'h0
`define IAP_K_CHIP 4'h1
`define IAP_K_BLOCK 4'h2
`define IAP_K_SECTOR 4'h3
`define IAP_K_PROG 4'h4
`define IAP_K_VERIFY 4'h5
`define IAP_K_SB1 4'h6
`define IAP_K_SB2 4'h7
`define IAP_K_SB3 4'h8
`define IAP_K_SC0 4'h9
`define IAP_K_SC1 4'hA
`define IAP_K_CLKD 4'hB
// ==================================================
// key values and address fields
`define IAP_KEY_ERASE 8'h55
`define IAP_KEY_SEC 8'hAA
`define IAP_KEY_SC0 8'h5A
`define IAP_KEY_SC1 8'hAA
`define IAP_KEY_CLKD 8'h55
`define IAP_BLK1_NIBBLE 4'hE
`define IAP_SECTOR_BYTES 8'h80
`define IAP_ERASED 8'hFF
`define IAP_ID_MFR_ADDR 8'h30
`define IAP_ID_DEV_ADDR 8'h31
`define IAP_LOCK_LEVEL4 3'h4
// ==================================================
// timing: op lengths in oscillator ticks, divider in clock cycles per tick; status busy bit
`define IAP_PROG_TICKS 8'h14
`define IAP_ERASE_TICKS 8'hC8
`define IAP_OSC_DIV 4'h4
`define IAP_STS_BUSY_BIT 2
`endif

//--- rtl/iap_decode.v
// command decoder: command byte plus mailbox keys to an operation code
`timescale 1ns/1ns
`include "iap_map.vh"
module iap_decode
(
   // command mailbox
   input wire [6:0] i_cmd,
   input wire [7:0] i_data,
   input wire [7:0] i_addr_hi,
   // decoded operation
   output reg [3:0] o_kind
);
   // ==================================================
   // decode
   always @*
   begin
      o_kind = `IAP_K_NONE;
      case (i_cmd) // [R22]
         `IAP_OP_CHIP_ERASE:
            if (i_data == `IAP_KEY_ERASE)
               o_kind = `IAP_K_CHIP;
         `IAP_OP_BLOCK_ERASE:
            if (i_data == `IAP_KEY_ERASE)
               o_kind = `IAP_K_BLOCK;
         `IAP_OP_SECTOR_ERASE:
            o_kind = `IAP_K_SECTOR;
         `IAP_OP_BYTE_PROG:
            o_kind = `IAP_K_PROG;
         `IAP_OP_BYTE_VERIFY:
            o_kind = `IAP_K_VERIFY;
         `IAP_OP_PROG_SB1:
            if (i_data == `IAP_KEY_SEC)
               o_kind = `IAP_K_SB1;
         `IAP_OP_PROG_SB2:
            if (i_data == `IAP_KEY_SEC)
               o_kind = `IAP_K_SB2;
         `IAP_OP_PROG_SB3:
            if (i_data == `IAP_KEY_SEC)
               o_kind = `IAP_K_SB3;
         `IAP_OP_PROG_SC:
            if (i_data == `IAP_KEY_SEC && i_addr_hi == `IAP_KEY_SC0)
               o_kind = `IAP_K_SC0;
            else if (i_data == `IAP_KEY_SEC && i_addr_hi == `IAP_KEY_SC1)
               o_kind = `IAP_K_SC1;
         `IAP_OP_CLK_DOUBLE:
            if (i_data == `IAP_KEY_SEC && i_addr_hi == `IAP_KEY_CLKD)
               o_kind = `IAP_K_CLKD;
         default:
            o_kind = `IAP_K_NONE;
      endcase
   end
endmodule

//--- rtl/iap_osc.v
// on-demand timing oscillator: runs only while enabled, counts ticks
`timescale 1ns/1ns
`include "iap_map.vh"
module iap_osc
(
   // clock and reset
   input wire i_clk,
   input wire i_rstn,
   // control
   input wire i_run,
   input wire [7:0] i_ticks,
   // status
   output reg o_done,
   output reg o_running
);
   reg [3:0] div_q;
   reg [7:0] cnt_q;
   wire tick;
   // the divider stands still and clears whenever not asked to run
   assign tick = (div_q == `IAP_OSC_DIV - 4'h1);
   // ==================================================
   // divider and tick counter
   always @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         div_q <= 4'h0;
         cnt_q <= 8'h00;
         o_done <= 1'b0;
         o_running <= 1'b0;
      end
      else if (!i_run)
      begin
         div_q <= 4'h0; // [R14]
         cnt_q <= 8'h00;
         o_done <= 1'b0;
         o_running <= 1'b0;
      end
      else
      begin
         o_running <= 1'b1; // [R14]
         o_done <= 1'b0;
         if (tick)
         begin
            div_q <= 4'h0;
            if (cnt_q + 8'h01 >= i_ticks)
               o_done <= 1'b1;
            else
               cnt_q <= cnt_q + 8'h01;
         end
         else
            div_q <= div_q + 4'h1;
      end
   end
endmodule

//--- rtl/iap_seq.v
// in-application flash command sequencer top level
`timescale 1ns/1ns
`include "iap_map.vh"
// How it works
// R1 - with the enable config bit clear, every command is ignored
// R2 - an operation starts only on the command byte write; mailboxes first
// R3 - a command aimed at a locked block is refused, array untouched
// R4 - software programs only erased bytes, erasing first otherwise
// R5 - chip erase clears both blocks, only while external access pin low
// R6 - chip erase refused at lock level four
// R7 - chip erase ignores locks and also clears lock and remap bits
// R8 - block erase: high bit 0 picks primary, top nibble E secondary
// R9 - code in one block always targets the other block
// R10 - code from external memory targets by address and bank selection
// R11 - code never programs the block it resides in
// R12 - bank selection can overlay secondary on lowest 8 KByte of primary
// R13 - unmapped block is still programmable from code in the other block
// R14 - timing oscillator runs on demand, stops when the operation ends
// R15 - identification read gives maker byte at 30H, device byte at 31H
// R16 - fetch from the other block or external memory continues meanwhile
// R17 - software never erases or programs the block it fetches from
// R18 - busy status bit held high while an operation runs
// R19 - command bit seven selects an internal completion interrupt
// R20 - sector erase clears the 128-byte sector addressed
// R21 - byte program writes data mailbox into the addressed byte
// R22 - low seven command bits decode to one operation, unknown ignored
// R23 - a command written while busy does not start
module iap_seq
#(
   parameter [7:0] MFR_ID = 8'h11, // arbitrary value
   parameter [7:0] DEV_ID = 8'h22 // arbitrary value
)
(
   // clock and reset
   input wire i_clk,
   input wire i_rstn,
   // mailbox registers from the core
   input wire [7:0] i_flash_config_reg,
   input wire [7:0] i_flash_addr_high_reg,
   input wire [7:0] i_flash_addr_low_reg,
   input wire [7:0] i_flash_data_mailbox,
   input wire [7:0] i_flash_command_reg,
   input wire i_cmd_wr,
   // fetch source: 0 primary, 1 secondary, 2 external
   input wire [1:0] i_fetch_src,
   // pins and security state
   input wire i_external_access_n,
   input wire i_lock_blk0,
   input wire i_lock_blk1,
   input wire [2:0] i_lock_level,
   // array data for verify
   input wire [7:0] i_array_rdata,
   // status and completion
   output reg [7:0] o_flash_status_reg,
   output reg o_ext_interrupt_one,
   output reg o_ext_interrupt_one_pin_blocked,
   output reg [7:0] o_verify_data,
   output reg o_verify_valid,
   // array operation strobes
   output reg o_erase_chip,
   output reg o_erase_blk0,
   output reg o_erase_blk1,
   output reg o_erase_sector,
   output reg o_prog_byte,
   output reg o_prog_blk1,
   output reg [15:0] o_addr,
   output reg [7:0] o_wdata,
   output reg o_clear_security,
   output reg [4:0] o_sec_prog,
   output reg o_clk_double,
   output reg o_osc_on
);
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_RUN = 2'h1;
   localparam [1:0] ST_DONE = 2'h2;
   localparam [1:0] SRC_BLK0 = 2'h0;
   localparam [1:0] SRC_BLK1 = 2'h1;
   // ==================================================
   // pin synchroniser
   // resets to internal execution until the pin is seen low twice
   reg ea_s1_q;
   reg ea_s2_q;
   always @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         ea_s1_q <= 1'b1;
         ea_s2_q <= 1'b1;
      end
      else
      begin
         ea_s1_q <= i_external_access_n;
         ea_s2_q <= ea_s1_q;
      end
   end
   // ==================================================
   // decode and target selection
   wire [3:0] kind;
   iap_decode u_dec
   (
      .i_cmd(i_flash_command_reg[6:0]),
      .i_data(i_flash_data_mailbox),
      .i_addr_hi(i_flash_addr_high_reg),
      .o_kind(kind)
   );
   // top nibble E names the secondary block outright
   function hi_blk1;
      input [7:0] ah;
      begin
         hi_blk1 = ah[7:4] == `IAP_BLK1_NIBBLE;
      end
   endfunction
   // block from address with overlay; 1 means secondary block
   function addr_blk1;
      input [7:0] ah;
      input [1:0] bank;
      input ea_n;
      begin
         if (hi_blk1(ah))
            addr_blk1 = 1'b1;
         // overlay of the secondary block onto the lowest 8 KByte
         else if (ah[7:5] == 3'h0 && (bank != 2'h0 || !ea_n))
            addr_blk1 = 1'b1; // [R12]
         else
            addr_blk1 = 1'b0;
      end
   endfunction
   // the physical fetch source decides; only external code reads the address
   reg tgt_blk1;
   always @*
   begin
      tgt_blk1 = 1'b0;
      case (i_fetch_src)
         SRC_BLK0: tgt_blk1 = 1'b1; // [R9] [R11] [R13]
         SRC_BLK1: tgt_blk1 = 1'b0; // [R9] [R11] [R13]
         default: tgt_blk1 = addr_blk1(i_flash_addr_high_reg,
            i_flash_config_reg[`IAP_CFG_BANK_HI:`IAP_CFG_BANK_LO],
            ea_s2_q); // [R10]
      endcase
   end
   // block erase picks block by address bits, refusing other patterns
   wire blk_sel0 = !i_flash_addr_high_reg[7]; // [R8]
   wire blk_sel1 = hi_blk1(i_flash_addr_high_reg); // [R8]
   wire erase_tgt1 = (i_fetch_src == SRC_BLK0) ? 1'b1 :
      (i_fetch_src == SRC_BLK1) ? 1'b0 : blk_sel1;
   wire erase_ok = (i_fetch_src == SRC_BLK0) ? blk_sel1 :
      (i_fetch_src == SRC_BLK1) ? blk_sel0 : (blk_sel0 | blk_sel1);
   wire locked = tgt_blk1 ? i_lock_blk1 : i_lock_blk0;
   wire elocked = erase_tgt1 ? i_lock_blk1 : i_lock_blk0;
   wire sec_src_ok = i_fetch_src != SRC_BLK0;
   wire chip_ok = !ea_s2_q && i_lock_level != `IAP_LOCK_LEVEL4; // [R5] [R6]
   wire ena = i_flash_config_reg[`IAP_CFG_ENABLE_BIT];
   wire irq_req = i_flash_command_reg[`IAP_CMD_IRQ_BIT];
   // ==================================================
   // acceptance
   reg [1:0] st_q;
   reg [1:0] st_d;
   reg accept;
   // a refused command leaves every strobe low and busy clear
   always @*
   begin
      accept = 1'b0;
      case (kind)
         `IAP_K_CHIP: accept = chip_ok; // [R7] locks disregarded
         `IAP_K_BLOCK: accept = erase_ok && !elocked; // [R3]
         `IAP_K_SECTOR, `IAP_K_PROG: accept = !locked; // [R3]
         `IAP_K_SB1, `IAP_K_SB2, `IAP_K_SB3, `IAP_K_SC0, `IAP_K_SC1,
         `IAP_K_CLKD: accept = sec_src_ok;
         default: accept = 1'b0;
      endcase
   end
   // a write lands only while idle and enabled
   wire go = i_cmd_wr && ena && st_q == ST_IDLE; // [R1] [R2] [R23]
   // identification slot: 1 maker byte, 2 device byte, 0 a plain read
   function [1:0] id_slot;
      input [7:0] ah;
      input [7:0] al;
      begin
         id_slot = 2'h0;
         if (ah == 8'h00 && al == `IAP_ID_MFR_ADDR)
            id_slot = 2'h1; // [R15]
         else if (ah == 8'h00 && al == `IAP_ID_DEV_ADDR)
            id_slot = 2'h2; // [R15]
      end
   endfunction
   wire [1:0] id_hit = id_slot(i_flash_addr_high_reg, i_flash_addr_low_reg);
   // ==================================================
   // timer
   reg [7:0] ticks_q;
   reg irq_mode_q;
   wire osc_done;
   wire osc_run;
   // runs only in the run state, so the ticks stop as the op ends
   iap_osc u_osc
   (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_run(st_q == ST_RUN),
      .i_ticks(ticks_q),
      .o_done(osc_done),
      .o_running(osc_run)
   );
   // done lasts one cycle so busy falls as the interrupt pulses
   always @*
   begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: if (go && accept) st_d = ST_RUN;
         ST_RUN: if (osc_done) st_d = ST_DONE; // [R14]
         ST_DONE: st_d = ST_IDLE;
         default: st_d = ST_IDLE;
      endcase
   end
   // ==================================================
   // state, strobes and status
   always @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         st_q <= ST_IDLE;
         ticks_q <= `IAP_PROG_TICKS;
         irq_mode_q <= 1'b0;
         o_flash_status_reg <= 8'h00;
         o_ext_interrupt_one <= 1'b0;
         o_ext_interrupt_one_pin_blocked <= 1'b0;
         o_verify_data <= 8'h00;
         o_verify_valid <= 1'b0;
         o_erase_chip <= 1'b0;
         o_erase_blk0 <= 1'b0;
         o_erase_blk1 <= 1'b0;
         o_erase_sector <= 1'b0;
         o_prog_byte <= 1'b0;
         o_prog_blk1 <= 1'b0;
         o_addr <= 16'h0000;
         o_wdata <= 8'h00;
         o_clear_security <= 1'b0;
         o_sec_prog <= 5'h00;
         o_clk_double <= 1'b0;
         o_osc_on <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         o_osc_on <= osc_run; // [R14]
         o_erase_chip <= 1'b0;
         o_erase_blk0 <= 1'b0;
         o_erase_blk1 <= 1'b0;
         o_erase_sector <= 1'b0;
         o_prog_byte <= 1'b0;
         o_clear_security <= 1'b0;
         o_sec_prog <= 5'h00;
         o_verify_valid <= 1'b0;
         o_ext_interrupt_one <= 1'b0;
         // fetch elsewhere is never stalled; only the array is busy [R16]
         o_flash_status_reg[`IAP_STS_BUSY_BIT] <= st_d != ST_IDLE; // [R18]
         if (go && kind == `IAP_K_VERIFY)
         begin
            // short read: no busy, no interrupt
            o_verify_valid <= 1'b1;
            if (id_hit == 2'h1)
               o_verify_data <= MFR_ID; // [R15]
            else if (id_hit == 2'h2)
               o_verify_data <= DEV_ID; // [R15]
            else
               o_verify_data <= i_array_rdata;
         end
         if (go && accept && st_q == ST_IDLE)
         begin
            irq_mode_q <= irq_req;
            o_ext_interrupt_one_pin_blocked <= irq_req; // [R19]
            o_addr <= {i_flash_addr_high_reg, i_flash_addr_low_reg};
            o_wdata <= i_flash_data_mailbox;
            o_prog_blk1 <= (kind == `IAP_K_BLOCK) ? erase_tgt1 : tgt_blk1;
            ticks_q <= (kind == `IAP_K_PROG) ? `IAP_PROG_TICKS :
               `IAP_ERASE_TICKS;
            case (kind)
               `IAP_K_CHIP:
               begin
                  o_erase_chip <= 1'b1; // [R5]
                  o_clear_security <= 1'b1; // [R7]
               end
               `IAP_K_BLOCK:
               begin
                  o_erase_blk0 <= !erase_tgt1; // [R8]
                  o_erase_blk1 <= erase_tgt1; // [R8]
               end
               // array clears the 128-byte sector holding o_addr
               `IAP_K_SECTOR: o_erase_sector <= 1'b1; // [R20]
               `IAP_K_PROG: o_prog_byte <= 1'b1; // [R21]
               `IAP_K_SB1: o_sec_prog <= 5'h01;
               `IAP_K_SB2: o_sec_prog <= 5'h02;
               `IAP_K_SB3: o_sec_prog <= 5'h04;
               `IAP_K_SC0: o_sec_prog <= 5'h08;
               `IAP_K_SC1: o_sec_prog <= 5'h10;
               `IAP_K_CLKD: o_clk_double <= 1'b1;
               default: o_sec_prog <= 5'h00;
            endcase
         end
         if (st_q == ST_DONE)
         begin
            o_ext_interrupt_one <= irq_mode_q; // [R19]
            o_ext_interrupt_one_pin_blocked <= 1'b0;
         end
      end
   end
endmodule

//--- testbench/iap_seq_assertions.sv
// port checker for the flash command sequencer
`timescale 1ns/1ns
module iap_seq_chk
#(
   parameter [7:0] MFR_ID = 8'h11,
   parameter [7:0] DEV_ID = 8'h22
)
(
   // clock, reset and mailbox
   input wire i_clk,
   input wire i_rstn,
   input wire [7:0] i_flash_config_reg,
   input wire [7:0] i_flash_addr_high_reg,
   input wire [7:0] i_flash_addr_low_reg,
   input wire [7:0] i_flash_data_mailbox,
   input wire i_cmd_wr,
   input wire [2:0] i_lock_level,
   // observed outputs
   input wire [7:0] o_flash_status_reg,
   input wire o_ext_interrupt_one,
   input wire [7:0] o_verify_data,
   input wire o_verify_valid,
   input wire o_erase_chip,
   input wire o_erase_sector,
   input wire o_prog_byte,
   input wire [15:0] o_addr,
   input wire [7:0] o_wdata,
   input wire o_clear_security,
   input wire o_osc_on
);
   wire busy = o_flash_status_reg[2];
   wire [15:0] mb = {i_flash_addr_high_reg, i_flash_addr_low_reg};
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rstn);
   // ==========================================
   // assertions
   prog_start_a: assert property (
      o_prog_byte |-> $past(i_cmd_wr) && $past(i_flash_config_reg[6]))
      else $error("program strobe without enabled command write");
   prog_data_a: assert property (
      o_prog_byte |-> o_addr == $past(mb)
      && o_wdata == $past(i_flash_data_mailbox))
      else $error("program address or data wrong");
   chip_level_a: assert property (
      o_erase_chip |-> $past(i_lock_level) != 3'h4)
      else $error("chip erase at lock level four");
   chip_clear_a: assert property (
      o_erase_chip |-> o_clear_security)
      else $error("chip erase kept the security bits");
   sector_addr_a: assert property (
      o_erase_sector |-> o_addr == $past(mb))
      else $error("sector erase address wrong");
   busy_hold_a: assert property (
      $rose(busy) |-> busy [*8])
      else $error("busy dropped too early");
   busy_drop_a: assert property (
      busy && i_cmd_wr |=> !o_prog_byte && !o_erase_sector && !o_erase_chip)
      else $error("command started while busy");
   osc_stop_a: assert property (
      $fell(busy) |-> ##[0:3] !o_osc_on)
      else $error("oscillator left running");
   irq_done_a: assert property (
      o_ext_interrupt_one |-> $fell(busy))
      else $error("completion interrupt off the busy drop");
   id_read_a: assert property (
      o_verify_valid |-> ($past(mb) != 16'h0030 || o_verify_data == MFR_ID)
      && ($past(mb) != 16'h0031 || o_verify_data == DEV_ID))
      else $error("identification byte wrong");
   cover property (o_prog_byte);
   cover property (o_erase_chip);
   cover property (o_ext_interrupt_one);
endmodule
bind iap_seq iap_seq_chk #(.MFR_ID(MFR_ID), .DEV_ID(DEV_ID)) iap_seq_chk_inst (
   .i_clk(i_clk), .i_rstn(i_rstn), .i_flash_config_reg(i_flash_config_reg),
   .i_flash_addr_high_reg(i_flash_addr_high_reg),
   .i_flash_addr_low_reg(i_flash_addr_low_reg),
   .i_flash_data_mailbox(i_flash_data_mailbox), .i_cmd_wr(i_cmd_wr),
   .i_lock_level(i_lock_level), .o_flash_status_reg(o_flash_status_reg),
   .o_ext_interrupt_one(o_ext_interrupt_one), .o_verify_data(o_verify_data),
   .o_verify_valid(o_verify_valid), .o_erase_chip(o_erase_chip),
   .o_erase_sector(o_erase_sector), .o_prog_byte(o_prog_byte),
   .o_addr(o_addr), .o_wdata(o_wdata), .o_osc_on(o_osc_on),
   .o_clear_security(o_clear_security));

//--- testbench/iap_core_model.sv
// processor core model: loads mailboxes and writes command bytes
`timescale 1ns/1ns
module iap_core_model
(
   // clock and status
   input wire i_clk,
   input wire [7:0] i_flash_status_reg,
   // mailbox writes
   output reg [7:0] o_flash_config_reg = 8'h00,
   output reg [7:0] o_flash_addr_high_reg = 8'h00,
   output reg [7:0] o_flash_addr_low_reg = 8'h00,
   output reg [7:0] o_flash_data_mailbox = 8'h00,
   output reg [7:0] o_flash_command_reg = 8'h00,
   output reg o_cmd_wr = 1'b0,
   output reg [1:0] o_fetch_src = 2'h0
);
   // mailboxes settle a full cycle before the command byte lands
   task issue(input [7:0] c, h, l, d, k, input [1:0] s);
      begin
         @(posedge i_clk);
         #10;
         o_flash_config_reg = c;
         o_flash_addr_high_reg = h;
         o_flash_addr_low_reg = l;
         o_flash_data_mailbox = d;
         o_fetch_src = s;
         @(posedge i_clk);
         #10;
         o_flash_command_reg = k;
         o_cmd_wr = 1'b1;
         @(posedge i_clk);
         #10;
         o_cmd_wr = 1'b0;
      end
   endtask
   // polls busy low, bounded so a hung operation reports instead
   task wait_idle(output logic ok);
      integer n;
      begin
         ok = 1'b0;
         for (n = 0; n < 1000 && !ok; n = n + 1)
         begin
            if (i_flash_status_reg[2] === 1'b0)
               ok = 1'b1;
            else
               @(posedge i_clk);
            #10;
         end
      end
   endtask
endmodule

//--- testbench/tb_top.sv
// self-checking bench for the flash command sequencer
`timescale 1ns/1ns
module tb_top;
   localparam [7:0] MFR = 8'h3C; // arbitrary value
   localparam [7:0] DEV = 8'h4D; // arbitrary value
   reg i_clk = 1'b0;
   reg i_rstn = 1'b0;
   reg ea_n = 1'b1;
   reg lk0 = 1'b0;
   reg lk1 = 1'b0;
   reg [2:0] lvl = 3'h0;
   reg [7:0] seen = 8'h00;
   reg [4:0] sec_seen = 5'h00;
   wire [7:0] cfg, ah, al, dat, cmd, sts, vdat, wd;
   wire [15:0] addr;
   wire [1:0] src;
   wire cw, irq, vv, ech, eb0, eb1, esec, prg, pb1, clr, osc;
   wire pinb, clkd;
   wire [4:0] sec;
   integer mismatches = 0;
   integer samples_checked = 0;
   iap_core_model core_inst (.i_clk(i_clk), .i_flash_status_reg(sts),
      .o_flash_config_reg(cfg), .o_flash_addr_high_reg(ah),
      .o_flash_addr_low_reg(al), .o_flash_data_mailbox(dat),
      .o_flash_command_reg(cmd), .o_cmd_wr(cw), .o_fetch_src(src));
   iap_seq #(.MFR_ID(MFR), .DEV_ID(DEV)) iap_seq_inst (.i_clk(i_clk),
      .i_rstn(i_rstn), .i_flash_config_reg(cfg), .i_flash_addr_high_reg(ah),
      .i_flash_addr_low_reg(al), .i_flash_data_mailbox(dat),
      .i_flash_command_reg(cmd), .i_cmd_wr(cw), .i_fetch_src(src),
      .i_external_access_n(ea_n), .i_lock_blk0(lk0), .i_lock_blk1(lk1),
      .i_lock_level(lvl), .i_array_rdata(8'h00), .o_flash_status_reg(sts),
      .o_ext_interrupt_one(irq), .o_ext_interrupt_one_pin_blocked(pinb),
      .o_verify_data(vdat),
      .o_verify_valid(vv), .o_erase_chip(ech), .o_erase_blk0(eb0),
      .o_erase_blk1(eb1), .o_erase_sector(esec), .o_prog_byte(prg),
      .o_prog_blk1(pb1), .o_addr(addr), .o_wdata(wd), .o_clk_double(clkd),
      .o_clear_security(clr), .o_sec_prog(sec), .o_osc_on(osc));
   // strobes are single pulses, so gather them per command
   always @(posedge i_clk)
      if (cw)
      begin
         seen <= 8'h00;
         sec_seen <= 5'h00;
      end
      else
      begin
         seen <= seen | {irq, vv, clr, prg, esec, eb1, eb0, ech};
         sec_seen <= sec_seen | sec;
      end
   initial
      forever #50 i_clk = ~i_clk;
   // ==========================================
   // checking and closing
   task chk(input string nm, input [15:0] e, input [15:0] g);
      begin
         samples_checked = samples_checked + 1;
         if (g !== e)
         begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task end_sim;
      begin
         $display("checks %0d mismatches %0d", samples_checked, mismatches);
         if (mismatches == 0 && samples_checked > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   task op(input [7:0] c, h, l, d, k, input [1:0] s, input [7:0] e);
      logic ok;
      begin
         core_inst.issue(c, h, l, d, k, s);
         core_inst.wait_idle(ok);
         if (!ok)
         begin
            mismatches = mismatches + 1;
            end_sim;
         end
         else
         begin
            repeat (3) @(posedge i_clk);
            #10;
            chk("strobes", {8'h00, e}, {8'h00, seen});
         end
      end
   endtask
   // ==========================================
   // scenarios
   task t_refuse;
      begin
         op(8'h00, 8'h12, 8'h34, 8'h5A, 8'h0E, 2'h0, 8'h00);
         op(8'h40, 8'h00, 8'h00, 8'h00, 8'h7F, 2'h2, 8'h00);
         lk1 = 1'b1;
         op(8'h40, 8'h12, 8'h34, 8'h5A, 8'h0E, 2'h0, 8'h00);
         lk1 = 1'b0;
      end
   endtask
   task t_chip;
      begin
         op(8'h40, 8'h00, 8'h00, 8'h55, 8'h01, 2'h2, 8'h00);
         ea_n = 1'b0;
         lvl = 3'h4;
         op(8'h40, 8'h00, 8'h00, 8'h55, 8'h01, 2'h2, 8'h00);
         lvl = 3'h0;
         lk0 = 1'b1;
         lk1 = 1'b1;
         op(8'h40, 8'h00, 8'h00, 8'h55, 8'h01, 2'h2, 8'h21);
         lk0 = 1'b0;
         lk1 = 1'b0;
         ea_n = 1'b1;
      end
   endtask
   task t_block;
      begin
         op(8'h40, 8'h00, 8'h00, 8'h55, 8'h0D, 2'h2, 8'h02);
         op(8'h40, 8'hE0, 8'h00, 8'h55, 8'h0D, 2'h2, 8'h04);
         op(8'h40, 8'h80, 8'h00, 8'h55, 8'h0D, 2'h2, 8'h00);
         op(8'h40, 8'h00, 8'h00, 8'h55, 8'h0D, 2'h0, 8'h00);
      end
   endtask
   task t_prog;
      begin
         op(8'h40, 8'h12, 8'h34, 8'h5A, 8'h8E, 2'h0, 8'h90);
         chk("addr", 16'h1234, addr);
         chk("wdata", 16'h005A, {8'h00, wd});
         chk("target", 16'h0001, {15'h0000, pb1});
         chk("osc", 16'h0000, {15'h0000, osc});
         op(8'h40, 8'h01, 8'h00, 8'hA5, 8'h0E, 2'h1, 8'h10);
         chk("target", 16'h0000, {15'h0000, pb1});
      end
   endtask
   task t_bank;
      begin
         op(8'h41, 8'h01, 8'h00, 8'h11, 8'h0E, 2'h2, 8'h10);
         chk("target", 16'h0001, {15'h0000, pb1});
         op(8'h40, 8'h01, 8'h00, 8'h11, 8'h0E, 2'h2, 8'h10);
         chk("target", 16'h0000, {15'h0000, pb1});
      end
   endtask
   task t_busy;
      begin
         core_inst.issue(8'h40, 8'h20, 8'h00, 8'h33, 8'h0E, 2'h0);
         op(8'h40, 8'h20, 8'h80, 8'h00, 8'h0B, 2'h2, 8'h00);
         op(8'h40, 8'h20, 8'h80, 8'h00, 8'h0B, 2'h2, 8'h08);
         chk("addr", 16'h2080, addr);
      end
   endtask
   task t_id;
      begin
         op(8'h40, 8'h00, 8'h30, 8'h00, 8'h0C, 2'h2, 8'h40);
         chk("id", {8'h00, MFR}, {8'h00, vdat});
         op(8'h40, 8'h00, 8'h31, 8'h00, 8'h0C, 2'h2, 8'h40);
         chk("id", {8'h00, DEV}, {8'h00, vdat});
      end
   endtask
   task t_secure;
      begin
         core_inst.issue(8'h40, 8'h30, 8'h00, 8'h66, 8'h8E, 2'h0);
         chk("busy", 16'h0001, {15'h0000, sts[2]});
         chk("int1blk", 16'h0001, {15'h0000, pinb});
         repeat (2) @(posedge i_clk);
         #10;
         chk("osc", 16'h0001, {15'h0000, osc});
         op(8'h40, 8'h30, 8'h00, 8'h00, 8'h0C, 2'h0, 8'h80);
         chk("int1blk", 16'h0000, {15'h0000, pinb});
         op(8'h40, 8'h00, 8'h00, 8'hAA, 8'h0F, 2'h1, 8'h00);
         chk("secprog", 16'h0001, {11'h000, sec_seen});
         op(8'h40, 8'h5A, 8'h00, 8'hAA, 8'h09, 2'h2, 8'h00);
         chk("secprog", 16'h0008, {11'h000, sec_seen});
         op(8'h40, 8'h55, 8'h00, 8'hAA, 8'h08, 2'h2, 8'h00);
         chk("clkdbl", 16'h0001, {15'h0000, clkd});
      end
   endtask
   initial
   begin
      repeat (4) @(posedge i_clk);
      #10;
      i_rstn = 1'b1;
      t_refuse;
      t_chip;
      t_block;
      t_prog;
      t_bank;
      t_busy;
      t_id;
      t_secure;
      end_sim;
   end
endmodule
